// ==== rtl/jkf_master_slave.sv ====
`timescale 1ns/10ps
// Function
// - Falling variant: master tracks next state while clock high; slave loads on fall.
// - Rising variant: master tracks next state while clock low; slave loads on rise.
// - Active-low preset and clear override clock; preset forces one and wins over clear.
// - Next state: hold for 00, zero for 01, one for 10, toggle for 11.
// - Without preset or clear, output changes only at the active edge.
module jkf_master_slave #(
    parameter logic EDGE_SEL = jkf_pkg::EDGE_FALLING    // Active edge of jk_clk
) (
    input  wire logic clk_sys,          // System clock, 20 MHz
    input  wire logic rst_n,            // Asynchronous reset, active low
    input  wire logic jk_clk,           // Storage element clock, sampled on clk_sys
    input  wire logic jk_j,             // J input
    input  wire logic jk_k,             // K input
    input  wire logic async_preset_low, // Preset, active low, overrides clock
    input  wire logic async_clear_low,  // Clear, active low, overrides clock
    output logic      jk_q,             // Slave rank output
    output logic      jk_master         // Master rank state
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    if ((EDGE_SEL !== jkf_pkg::EDGE_FALLING) && (EDGE_SEL !== jkf_pkg::EDGE_RISING))
    begin : g_bad_edge
        $error("EDGE_SEL must select the falling or the rising variant");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state decode

    function automatic logic jk_next(input logic j, input logic k, input logic q_now);
        logic nxt;
        nxt = q_now;
        case ({j, k})
            2'h0: nxt = q_now;
            2'h1: nxt = 1'h0;
            2'h2: nxt = 1'h1;
            2'h3: nxt = ~q_now;
            default: nxt = q_now;
        endcase
        return nxt;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge and level decode

    logic clk_prev_q;
    logic master_q;
    logic master_d;
    logic slave_q;
    logic slave_d;

    wire logic rising_sel  = (EDGE_SEL == jkf_pkg::EDGE_RISING);
    // The level at which the master is open is the one just before the active edge
    wire logic open_level  = rising_sel ? ~jk_clk : jk_clk;
    // A jk_clk level that spans no rising clk_sys edge is never seen, so its edges are lost
    wire logic act_edge    = rising_sel ? (~clk_prev_q & jk_clk)
                                        : (clk_prev_q & ~jk_clk);
    wire logic force_one   = ~async_preset_low;
    wire logic force_zero  = async_preset_low & ~async_clear_low;
    wire logic async_idle  = async_preset_low & async_clear_low;
    // Toggle reads the visible output, which is the slave whenever the master is open
    wire logic jk_d        = jk_next(jk_j, jk_k, jk_q);

    // Controls act combinationally so they need no jk_clk or clk_sys edge to show
    assign jk_q      = force_one  ? jkf_pkg::PRESET_LEVEL :
                       force_zero ? jkf_pkg::CLEAR_LEVEL  : slave_q;
    assign jk_master = force_one  ? jkf_pkg::PRESET_LEVEL :
                       force_zero ? jkf_pkg::CLEAR_LEVEL  : master_q;

    assign master_d   = force_one  ? jkf_pkg::PRESET_LEVEL :
                        force_zero ? jkf_pkg::CLEAR_LEVEL  :
                        open_level ? jk_d : master_q;
    // Slave takes the master as it stood before the edge; the master is closed then
    assign slave_d    = force_one  ? jkf_pkg::PRESET_LEVEL :
                        force_zero ? jkf_pkg::CLEAR_LEVEL  :
                        act_edge   ? master_q : slave_q;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    // Edge history resets low; the one false rising edge this may give after reset
    // copies a master that still holds the same reset value as the slave
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_prev_q <= 1'h0;
        end
        else
        begin
            clk_prev_q <= jk_clk;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_q <= jkf_pkg::MASTER_RST;
        end
        else
        begin
            master_q <= master_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slave_q <= jkf_pkg::SLAVE_RST;
        end
        else
        begin
            slave_q <= slave_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Sampled rst_n keeps an attempt off the edge at which the flops still sat in reset
    sequence s_quiet_edge;
        rst_n && act_edge && async_idle;
    endsequence

    sequence s_quiet_open;
        rst_n && open_level && async_idle;
    endsequence

    sequence s_quiet_closed;
        rst_n && !open_level && async_idle;
    endsequence

    sequence s_preset_seen;
        rst_n && !async_preset_low;
    endsequence

    sequence s_clear_seen;
        rst_n && async_preset_low && !async_clear_low;
    endsequence

    // A forced level shows at once on the pins and sits in both flops a cycle later
    sequence s_ranks_one;
        (jk_q && jk_master) ##1 (slave_q && master_q);
    endsequence

    sequence s_ranks_zero;
        (!jk_q && !jk_master) ##1 (!slave_q && !master_q);
    endsequence

    if (EDGE_SEL == jkf_pkg::EDGE_FALLING)
    begin : g_chk_fall
        chk_slave_fall_load: assert property (
            @(posedge clk_sys) disable iff (!rst_n)
            (rst_n && clk_prev_q && !jk_clk && async_idle) |=> (slave_q == $past(master_q)))
            else $error("slave did not load master on falling edge");
    end
    else
    begin : g_chk_rise
        chk_slave_rise_load: assert property (
            @(posedge clk_sys) disable iff (!rst_n)
            (rst_n && !clk_prev_q && jk_clk && async_idle) |=> (slave_q == $past(master_q)))
            else $error("slave did not load master on rising edge");
    end

    chk_master_follow: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_quiet_open |=> (master_q == $past(jk_d)))
        else $error("master did not follow next-state value while open");

    chk_master_closed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_quiet_closed |=> (master_q == $past(master_q)))
        else $error("master moved while closed");

    chk_preset_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_preset_seen |-> s_ranks_one)
        else $error("preset did not force both ranks to one");

    chk_preset_over_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!async_preset_low && !async_clear_low) |-> (jk_q && jk_master))
        else $error("clear overrode preset");

    chk_clear_forces_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_clear_seen |-> s_ranks_zero)
        else $error("clear did not force both ranks to zero");

    chk_toggle_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_quiet_open and (jk_j && jk_k)) |=> (master_q == !$past(jk_q)))
        else $error("J=K=1 did not capture complement of output");

    chk_reset_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_quiet_open and (!jk_j && jk_k)) |=> !master_q)
        else $error("J=0 K=1 did not capture zero");

    chk_set_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_quiet_open and (jk_j && !jk_k)) |=> master_q)
        else $error("J=1 K=0 did not capture one");

    chk_hold_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_quiet_open and (!jk_j && !jk_k)) |=> (master_q == $past(jk_q)))
        else $error("J=K=0 did not capture present output");

    chk_output_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && !act_edge && async_idle) |=> (slave_q == $past(slave_q)))
        else $error("output changed away from an active edge");

    chk_output_still: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && !act_edge && async_idle) ##1 async_idle |-> (jk_q == $past(jk_q)))
        else $error("visible output moved away from an active edge");

    chk_edge_output: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_quiet_edge ##1 async_idle |-> (jk_q == $past(master_q)))
        else $error("output after active edge differs from master");

endmodule

// ==== rtl/jkf_pkg.sv ====
package jkf_pkg;

    // Encodings of the active-edge selection
    localparam logic EDGE_FALLING = 1'h0;
    localparam logic EDGE_RISING  = 1'h1;

    // Reset values of the two ranks
    localparam logic MASTER_RST   = 1'h0;
    localparam logic SLAVE_RST    = 1'h0;

    // Levels forced by the asynchronous controls
    localparam logic PRESET_LEVEL = 1'h1;
    localparam logic CLEAR_LEVEL  = 1'h0;

    // Number of clk_sys cycles from an active edge to the updated output
    localparam int   EDGE_TO_OUT  = 1;

endpackage

// ==== verification/jkf_far_logic.sv ====
`timescale 1ns/10ps
// Registered drive, so every jk_clk level lasts at least one clk_sys cycle
module jkf_far_logic (
    input  wire logic        clk_sys,          // System clock
    input  wire logic [11:0] rnd,              // Random word from the bench
    output logic             jk_clk,           // Storage element clock
    output logic             jk_j,             // J
    output logic             jk_k,             // K
    output logic             async_preset_low, // Preset, active low
    output logic             async_clear_low   // Clear, active low
);
    always_ff @(posedge clk_sys)
    begin
        jk_clk           <= rnd[0];
        jk_j             <= rnd[1];
        jk_k             <= rnd[2];
        // Rare pulses, so the clocked path gets most of the run
        async_preset_low <= |rnd[7:4];
        async_clear_low  <= |rnd[11:8];
    end
endmodule

// ==== verification/jkf_master_slave_tb.sv ====
`timescale 1ns/10ps
module jkf_master_slave_tb;
    logic        clk_sys = 1'h0;
    logic        rst_n   = 1'h0;
    logic [11:0] rnd     = 12'hfff;
    logic        jk_clk, jk_j, jk_k, pre_n, clr_n;
    logic [1:0]  jk_q, jk_master;
    int          fail_count = 0;
    int          n_compared = 0;
    bit          m_q [2];
    bit          s_q [2];
    bit          prev_q, nxt_d, exp_d;

    always #25 clk_sys = ~clk_sys;

    jkf_far_logic jkf_far_logic_i (.clk_sys(clk_sys), .rnd(rnd), .jk_clk(jk_clk), .jk_j(jk_j),
        .jk_k(jk_k), .async_preset_low(pre_n), .async_clear_low(clr_n));

    for (genvar v = 0; v < 2; v++)
    begin : g_var
        jkf_master_slave #(.EDGE_SEL(v == 1 ? jkf_pkg::EDGE_RISING : jkf_pkg::EDGE_FALLING))
            jkf_master_slave_i (.clk_sys(clk_sys), .rst_n(rst_n), .jk_clk(jk_clk), .jk_j(jk_j),
            .jk_k(jk_k), .async_preset_low(pre_n), .async_clear_low(clr_n),
            .jk_q(jk_q[v]), .jk_master(jk_master[v]));
    end

    task automatic check(logic got, bit exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t output %b, model %b", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Model: variant 0 opens on jk_clk high, variant 1 on jk_clk low
    always @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            m_q = '{1'h0, 1'h0};
            s_q = '{1'h0, 1'h0};
            prev_q = 1'h0;
        end
        else
        begin
            for (int v = 0; v < 2; v++)
            begin
                nxt_d = (jk_j & ~s_q[v]) | (~jk_k & s_q[v]);
                if (!pre_n)
                    {m_q[v], s_q[v]} = 2'h3;
                else if (!clr_n)
                    {m_q[v], s_q[v]} = 2'h0;
                else if (jk_clk == v[0] && prev_q != jk_clk)
                    s_q[v] = m_q[v];
                else if (jk_clk != v[0])
                    m_q[v] = nxt_d;
            end
            prev_q = jk_clk;
        end

    always @(negedge clk_sys)
        if (rst_n)
            for (int v = 0; v < 2; v++)
            begin
                exp_d = !pre_n ? 1'h1 : (!clr_n ? 1'h0 : s_q[v]);
                check(jk_q[v], exp_d);
                exp_d = !pre_n ? 1'h1 : (!clr_n ? 1'h0 : m_q[v]);
                check(jk_master[v], exp_d);
            end

    initial
    begin
        void'($urandom(74));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        for (int n = 0; n < 3000; n++)
        begin
            @(posedge clk_sys);
            rnd <= 12'($urandom);
            // A second reset in mid-run
            rst_n <= (n < 1500 || n > 1503);
        end
        stop_test();
    end

    initial
    begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
